// file: hw/tlbm_top.sv
`timescale 1ns/10ps
`default_nettype none
module tlbm_top (
	// Clock and reset
	input  wire logic                    mclk,
	input  wire logic                    rstn,
	// Control register access
	input  wire logic                    cp0_wr,
	input  wire logic                    cp0_rd,
	input  wire logic [4:0]              cp0_num,
	input  wire logic [2:0]              cp0_sel,
	input  wire logic [31:0]             cp0_wdata,
	output logic      [31:0]             cp0_rdata,
	// Buffer maintenance instructions
	input  wire logic                    indexed_entry_write,
	input  wire logic                    random_entry_write,
	input  wire logic                    translation_probe,
	input  wire logic                    probe_hit,
	input  wire logic [5:0]              probe_entry,
	output logic                         buf_we,
	output logic      [5:0]              buf_we_entry,
	// Translation result of a load or store
	input  wire logic                    acc_valid,
	input  wire logic                    acc_store,
	input  wire logic                    acc_user_sup,
	input  wire logic                    acc_perm_ok,
	input  wire logic                    acc_hit,
	input  wire logic                    acc_entry_valid,
	input  wire logic                    acc_entry_dirty,
	input  wire logic [31:0]             acc_vaddr,
	output logic                         exc_valid,
	output tlbm_pkg::tlbm_exc_e          exc_code
);
	import tlbm_pkg::*;

	typedef struct packed {
		logic        probe_miss;
		logic [5:0]  index;
		logic [5:0]  wired;
		logic [31:0] ptr;
		logic [31:0] mask;
		logic [31:0] badva;
		logic [31:0] rdata;
		logic        we;
		logic [5:0]  we_entry;
		logic        exc_v;
		tlbm_exc_e   exc;
	} tlbm_state_s;

	tlbm_state_s state_reg;
	tlbm_state_s state_next;
	logic [5:0]  rand_idx;
	logic        wr_index;
	logic        wr_wired;
	logic        wr_ptr;
	logic        wr_mask;
	tlbm_exc_e   fault;

	assign wr_index = cp0_wr && cp0_num == NUM_INDEX && cp0_sel == SEL_0;
	assign wr_wired = cp0_wr && cp0_num == NUM_WIRED && cp0_sel == SEL_0;
	assign wr_ptr   = cp0_wr && cp0_num == NUM_PTR && cp0_sel == SEL_0;
	assign wr_mask  = cp0_wr && cp0_num == NUM_PTR && cp0_sel == SEL_MASK;

	// Merge the faulting page number into the pointer under the mask
	function automatic logic [31:0] insert_vpn(input logic [31:0] ptr,
		input logic [31:0] mask, input logic [31:0] va);
		logic [4:0]  top;
		logic [31:0] shifted;
		top = 5'h00;
		for (int i = 0; i < 32; i++) begin
			if (mask[i]) begin
				top = 5'(i);
			end
		end
		// Top of the field receives address bit 31
		shifted = va >> (5'h1F - top);
		return (ptr & ~mask) | (shifted & mask);
	endfunction

	// Fault classification; address errors outrank the buffer lookup
	always_comb begin
		fault = EXC_NONE;
		if (acc_valid) begin
			if (acc_user_sup && !acc_perm_ok) begin
				fault = acc_store ? EXC_ADDR_STORE : EXC_ADDR_LOAD;
			end else if (!acc_hit) begin
				fault = EXC_REFILL;
			end else if (!acc_entry_valid) begin
				fault = acc_store ? EXC_INV_STORE : EXC_INV_LOAD;
			end else if (acc_store && !acc_entry_dirty) begin
				fault = EXC_MODIFIED;
			end
		end
	end

	always_comb begin
		state_next       = state_reg;
		state_next.we    = 1'b0;
		state_next.exc_v = 1'b0;
		state_next.exc   = EXC_NONE;
		if (wr_index) begin
			state_next.index      = cp0_wdata[5:0];
			state_next.probe_miss = cp0_wdata[MISS_BIT];
		end
		// Probe result wins over a software write in the same cycle
		if (translation_probe) begin
			state_next.probe_miss = !probe_hit;
			if (probe_hit) begin
				state_next.index = probe_entry;
			end
		end
		if (wr_wired) begin
			state_next.wired = cp0_wdata[5:0];
		end
		if (wr_mask) begin
			// Unimplemented bits stay zero so software can size the field
			state_next.mask = cp0_wdata & MASK_IMPL;
		end
		if (wr_ptr) begin
			state_next.ptr = cp0_wdata;
		end
		if (indexed_entry_write) begin
			// Indexed write ignores the wired boundary
			state_next.we       = 1'b1;
			state_next.we_entry = state_reg.index;
		end else if (random_entry_write) begin
			state_next.we       = 1'b1;
			state_next.we_entry = rand_idx;
		end
		// Only address-error and buffer lookup faults reach here; cache and bus errors have no path in
		if (fault != EXC_NONE) begin
			state_next.exc_v = 1'b1;
			state_next.exc   = fault;
			state_next.badva = acc_vaddr;
			state_next.ptr   = insert_vpn(state_next.ptr, state_reg.mask, acc_vaddr);
		end
		state_next.rdata = state_reg.rdata;
		if (cp0_rd) begin
			state_next.rdata = RST_WORD;
			case ({cp0_num, cp0_sel})
				{NUM_INDEX, SEL_0}: begin
					state_next.rdata           = {26'h000_0000, state_reg.index};
					state_next.rdata[MISS_BIT] = state_reg.probe_miss;
				end
				{NUM_RAND, SEL_0}: begin
					state_next.rdata = {26'h000_0000, rand_idx};
				end
				{NUM_PTR, SEL_0}: begin
					state_next.rdata = state_reg.ptr;
				end
				{NUM_PTR, SEL_MASK}: begin
					state_next.rdata = state_reg.mask;
				end
				{NUM_WIRED, SEL_0}: begin
					state_next.rdata = {26'h000_0000, state_reg.wired};
				end
				{NUM_BADVA, SEL_0}: begin
					state_next.rdata = state_reg.badva;
				end
				default: begin
					state_next.rdata = RST_WORD;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_reg.probe_miss <= 1'b0;
			state_reg.index      <= RST_WIRED;
			state_reg.wired      <= RST_WIRED;
			state_reg.ptr        <= RST_WORD;
			state_reg.mask       <= RST_WORD;
			state_reg.badva      <= RST_WORD;
			state_reg.rdata      <= RST_WORD;
			state_reg.we         <= 1'b0;
			state_reg.we_entry   <= RST_WIRED;
			state_reg.exc_v      <= 1'b0;
			state_reg.exc        <= EXC_NONE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Random slot steps after each buffer write and restarts at the top on a boundary write, which wins in the same cycle
	tlbm_random_index u_rand (
		.mclk      (mclk),
		.rstn      (rstn),
		.wired_wr  (wr_wired),
		.wired_new (cp0_wdata[5:0]),
		.wired_cur (state_reg.wired),
		.buf_write (indexed_entry_write || random_entry_write),
		.rand_out  (rand_idx)
	);

	assign cp0_rdata    = state_reg.rdata;
	assign buf_we       = state_reg.we;
	assign buf_we_entry = state_reg.we_entry;
	assign exc_valid    = state_reg.exc_v;
	assign exc_code     = state_reg.exc;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	sequence s_perm_fault;
		acc_valid && acc_user_sup && !acc_perm_ok;
	endsequence

	sequence s_lookup;
		acc_valid && !(acc_user_sup && !acc_perm_ok);
	endsequence

	property p_idx_write;
		indexed_entry_write |=> buf_we && buf_we_entry == $past(state_reg.index);
	endproperty
	a_idx_write: assert property (p_idx_write)
		else $error("indexed write used wrong entry");

	property p_probe_miss;
		translation_probe && !probe_hit |=> state_reg.probe_miss;
	endproperty
	a_probe_miss: assert property (p_probe_miss)
		else $error("probe miss did not set bit 31");

	property p_probe_hit;
		translation_probe && probe_hit |=>
			!state_reg.probe_miss && state_reg.index == $past(probe_entry);
	endproperty
	a_probe_hit: assert property (p_probe_hit)
		else $error("probe hit not stored in index");

	property p_rand_write;
		random_entry_write && !indexed_entry_write |=>
			buf_we && buf_we_entry == $past(rand_idx) && buf_we_entry >= $past(state_reg.wired);
	endproperty
	a_rand_write: assert property (p_rand_write)
		else $error("random write hit a wired entry");

	property p_addr_err;
		s_perm_fault |=> exc_valid && exc_code == ($past(acc_store) ? EXC_ADDR_STORE : EXC_ADDR_LOAD);
	endproperty
	a_addr_err: assert property (p_addr_err)
		else $error("permission fault not reported as address error");

	property p_refill;
		s_lookup ##0 !acc_hit |=> exc_valid && exc_code == EXC_REFILL;
	endproperty
	a_refill: assert property (p_refill)
		else $error("miss did not raise refill");

	property p_invalid;
		s_lookup ##0 acc_hit && !acc_entry_valid |=>
			exc_code == ($past(acc_store) ? EXC_INV_STORE : EXC_INV_LOAD);
	endproperty
	a_invalid: assert property (p_invalid)
		else $error("invalid entry fault wrong");

	property p_modified;
		s_lookup ##0 acc_hit && acc_entry_valid && acc_store && !acc_entry_dirty |=>
			exc_code == EXC_MODIFIED;
	endproperty
	a_modified: assert property (p_modified)
		else $error("clean entry store not flagged modified");

	property p_badva;
		exc_valid |-> state_reg.badva == $past(acc_vaddr);
	endproperty
	a_badva: assert property (p_badva)
		else $error("fault address not captured");

	property p_zero_mask;
		state_reg.mask == 32'h0000_0000 && !wr_ptr |=> $stable(state_reg.ptr);
	endproperty
	a_zero_mask: assert property (p_zero_mask)
		else $error("pointer changed with zero mask");

	property p_outside_mask;
		fault != EXC_NONE && !wr_ptr |=>
			((state_reg.ptr ^ $past(state_reg.ptr)) & ~$past(state_reg.mask)) == 32'h0000_0000;
	endproperty
	a_outside_mask: assert property (p_outside_mask)
		else $error("fault touched pointer bits outside mask");

	property p_wired_reset_free;
		wr_wired |=> state_reg.wired == $past(cp0_wdata[5:0]) ##0 rand_idx == 6'h3F;
	endproperty
	a_wired_reset_free: assert property (p_wired_reset_free)
		else $error("wired write not taken");
endmodule
`default_nettype wire

// file: inc/tlbm_pkg.sv
package tlbm_pkg;
	localparam int          ENTRIES   = 64;
	localparam int          IDX_W     = 6;
	localparam int          MISS_BIT  = 31;
	localparam logic [5:0]  MAX_ENTRY = 6'h3F;
	localparam logic [5:0]  RST_WIRED = 6'h00;
	localparam logic [5:0]  RST_RAND  = 6'h3F;
	localparam logic [31:0] RST_WORD  = 32'h0000_0000;
	// Implemented mask bits; others read back zero
	localparam logic [31:0] MASK_IMPL = 32'h007F_FFFC;
	// Control register numbers and selects
	localparam logic [4:0]  NUM_INDEX = 5'h00;
	localparam logic [4:0]  NUM_RAND  = 5'h01;
	localparam logic [4:0]  NUM_PTR   = 5'h04;
	localparam logic [4:0]  NUM_WIRED = 5'h06;
	localparam logic [4:0]  NUM_BADVA = 5'h08;
	localparam logic [2:0]  SEL_0     = 3'h0;
	localparam logic [2:0]  SEL_MASK  = 3'h1;
	typedef enum logic [2:0] {
		EXC_NONE       = 3'h0,
		EXC_ADDR_LOAD  = 3'h1,
		EXC_ADDR_STORE = 3'h2,
		EXC_REFILL     = 3'h3,
		EXC_INV_LOAD   = 3'h4,
		EXC_INV_STORE  = 3'h5,
		EXC_MODIFIED   = 3'h6
	} tlbm_exc_e;
endpackage

// file: hw/tlbm_random_index.sv
`timescale 1ns/10ps
`default_nettype none
module tlbm_random_index (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rstn,
	// Events
	input  wire logic       wired_wr,
	input  wire logic [5:0] wired_new,
	input  wire logic [5:0] wired_cur,
	input  wire logic       buf_write,
	// Current replacement slot
	output logic      [5:0] rand_out
);
	import tlbm_pkg::*;

	typedef struct packed {
		logic [5:0] rnd;
	} tlbm_rnd_s;

	tlbm_rnd_s state_reg;
	tlbm_rnd_s state_next;

	always_comb begin
		state_next = state_reg;
		if (wired_wr) begin
			// Restart at the top so the slot is never inside the new wired range
			state_next.rnd = MAX_ENTRY;
		end else if (buf_write) begin
			// Walk down towards the boundary, then wrap to the top
			if (state_reg.rnd <= wired_cur) begin
				state_next.rnd = MAX_ENTRY;
			end else begin
				state_next.rnd = state_reg.rnd - 6'h01;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_reg.rnd <= RST_RAND;
		end else begin
			state_reg <= state_next;
		end
	end

	assign rand_out = state_reg.rnd;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	property p_rand_range;
		wired_cur <= rand_out;
	endproperty
	a_rand_range: assert property (p_rand_range)
		else $error("random slot below wired boundary");

	property p_rand_moves;
		buf_write && !wired_wr && rand_out > wired_cur |=> rand_out == $past(rand_out) - 6'h01;
	endproperty
	a_rand_moves: assert property (p_rand_moves)
		else $error("random slot did not step after buffer write");

	property p_wired_restart;
		wired_wr |=> rand_out == 6'h3F && rand_out >= $past(wired_new);
	endproperty
	a_wired_restart: assert property (p_wired_restart)
		else $error("random slot not restarted on wired write");
endmodule
`default_nettype wire

// file: verification/tlbm_tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	import tlbm_pkg::*;
	logic        mclk;
	logic        rstn;
	logic        cp0_wr;
	logic        cp0_rd;
	logic [4:0]  cp0_num;
	logic [2:0]  cp0_sel;
	logic [31:0] cp0_wdata;
	logic [31:0] cp0_rdata;
	logic        indexed_entry_write;
	logic        random_entry_write;
	logic        translation_probe;
	logic        probe_hit;
	logic [5:0]  probe_entry;
	logic        buf_we;
	logic [5:0]  buf_we_entry;
	logic        acc_valid;
	logic        acc_store;
	logic        acc_user_sup;
	logic        acc_perm_ok;
	logic        acc_hit;
	logic        acc_entry_valid;
	logic        acc_entry_dirty;
	logic [31:0] acc_vaddr;
	logic        exc_valid;
	tlbm_exc_e   exc_code;
	int          tests_run;
	int          miscompares;
	logic [31:0] last_va;
	logic [31:0] masks [4] = '{32'h0000_0000, 32'h003F_FFF8, 32'h007F_FFF0, 32'hFFFF_FFFF};
	int          shf [4] = '{0, 10, 9, 9};

	tlbm_top DUT (
		.mclk(mclk), .rstn(rstn),
		.cp0_wr(cp0_wr), .cp0_rd(cp0_rd), .cp0_num(cp0_num), .cp0_sel(cp0_sel),
		.cp0_wdata(cp0_wdata), .cp0_rdata(cp0_rdata),
		.indexed_entry_write(indexed_entry_write), .random_entry_write(random_entry_write),
		.translation_probe(translation_probe), .probe_hit(probe_hit),
		.probe_entry(probe_entry), .buf_we(buf_we), .buf_we_entry(buf_we_entry),
		.acc_valid(acc_valid), .acc_store(acc_store), .acc_user_sup(acc_user_sup),
		.acc_perm_ok(acc_perm_ok), .acc_hit(acc_hit), .acc_entry_valid(acc_entry_valid),
		.acc_entry_dirty(acc_entry_dirty), .acc_vaddr(acc_vaddr),
		.exc_valid(exc_valid), .exc_code(exc_code)
	);

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [4:0] num, input logic [2:0] sel, input logic [31:0] d);
		@(posedge mclk);
		cp0_wr    <= 1'b1;
		cp0_num   <= num;
		cp0_sel   <= sel;
		cp0_wdata <= d;
		@(posedge mclk);
		cp0_wr <= 1'b0;
	endtask

	// Data holds until the next read, so a late sample is safe
	task automatic rd(input logic [4:0] num, input logic [2:0] sel, input logic [31:0] exp);
		@(posedge mclk);
		cp0_rd  <= 1'b1;
		cp0_num <= num;
		cp0_sel <= sel;
		@(posedge mclk);
		cp0_rd <= 1'b0;
		@(posedge mclk);
		#1;
		check(cp0_rdata, exp);
	endtask

	task automatic bw(input logic ix, input logic rw, input logic [5:0] entry);
		@(posedge mclk);
		indexed_entry_write <= ix;
		random_entry_write  <= rw;
		@(posedge mclk);
		indexed_entry_write <= 1'b0;
		random_entry_write  <= 1'b0;
		#1;
		check(32'(buf_we), 32'h0000_0001);
		check(32'(buf_we_entry), 32'(entry));
		@(posedge mclk);
		#1;
		check(32'(buf_we), 32'h0000_0000);
	endtask

	task automatic probe(input logic hit, input logic [5:0] entry);
		@(posedge mclk);
		translation_probe <= 1'b1;
		probe_hit         <= hit;
		probe_entry       <= entry;
		@(posedge mclk);
		translation_probe <= 1'b0;
	endtask

	// Flags in f: store, user_sup, perm_ok, hit, entry_valid, entry_dirty
	task automatic acc(input logic [5:0] f, input logic [31:0] va, input tlbm_exc_e code);
		@(posedge mclk);
		{acc_store, acc_user_sup, acc_perm_ok, acc_hit, acc_entry_valid, acc_entry_dirty} <= f;
		acc_vaddr <= va;
		acc_valid <= 1'b1;
		@(posedge mclk);
		acc_valid <= 1'b0;
		#1;
		check(32'(exc_valid), 32'(code != EXC_NONE));
		check(32'(exc_code), 32'(code));
		if (code != EXC_NONE) last_va = va;
		@(posedge mclk);
		#1;
		check(32'(exc_valid), 32'h0000_0000);
		rd(NUM_BADVA, SEL_0, last_va);
	endtask

	task automatic pointer_capture();
		logic [31:0] mi;
		for (int i = 0; i < 4; i++) begin
			mi = masks[i] & MASK_IMPL;
			wr(NUM_PTR, SEL_0, 32'hA5A5_A5A5);
			wr(NUM_PTR, SEL_MASK, masks[i]);
			acc(6'h38, 32'h9876_5431 + 32'(i), EXC_REFILL);
			rd(NUM_PTR, SEL_0, (32'hA5A5_A5A5 & ~mi) | (last_va >> shf[i]) & mi);
		end
	endtask

	task automatic reset_values();
		rd(NUM_INDEX, SEL_0, 32'h0000_0000);
		rd(NUM_RAND, SEL_0, 32'h0000_003F);
		rd(NUM_WIRED, SEL_0, 32'h0000_0000);
		rd(NUM_PTR, SEL_MASK, 32'h0000_0000);
		rd(NUM_BADVA, SEL_0, 32'h0000_0000);
	endtask

	task automatic random_walk();
		bw(1'b0, 1'b1, 6'h3F);
		rd(NUM_RAND, SEL_0, 32'h0000_003E);
		wr(NUM_RAND, SEL_0, 32'h0000_0005);
		rd(NUM_RAND, SEL_0, 32'h0000_003E);
		wr(NUM_WIRED, SEL_0, 32'h0000_0005);
		rd(NUM_WIRED, SEL_0, 32'h0000_0005);
		rd(NUM_RAND, SEL_0, 32'h0000_003F);
		wr(NUM_INDEX, SEL_0, 32'h0000_0002);
		bw(1'b1, 1'b0, 6'h02);
		rd(NUM_RAND, SEL_0, 32'h0000_003E);
		wr(NUM_INDEX, SEL_0, 32'h0000_000A);
		bw(1'b1, 1'b1, 6'h0A);
		// Boundary of 62 leaves only entries 62 and 63 in rotation
		wr(NUM_WIRED, SEL_0, 32'h0000_003E);
		bw(1'b0, 1'b1, 6'h3F);
		bw(1'b0, 1'b1, 6'h3E);
		bw(1'b0, 1'b1, 6'h3F);
		wr(NUM_WIRED, SEL_0, 32'h0000_003F);
		bw(1'b0, 1'b1, 6'h3F);
		bw(1'b0, 1'b1, 6'h3F);
	endtask

	task automatic probe_index();
		probe(1'b1, 6'h07);
		rd(NUM_INDEX, SEL_0, 32'h0000_0007);
		probe(1'b0, 6'h21);
		rd(NUM_INDEX, SEL_0, 32'h8000_0007);
	endtask

	task automatic mask_sizing();
		wr(NUM_PTR, SEL_MASK, 32'hFFFF_FFFF);
		rd(NUM_PTR, SEL_MASK, MASK_IMPL);
		wr(NUM_PTR, SEL_MASK, 32'h0000_0000);
		rd(NUM_PTR, SEL_MASK, 32'h0000_0000);
	endtask

	task automatic fault_classes();
		acc(6'h17, 32'h1111_2000, EXC_ADDR_LOAD);
		acc(6'h30, 32'h2222_3000, EXC_ADDR_STORE);
		acc(6'h03, 32'h3333_4000, EXC_REFILL);
		acc(6'h38, 32'h4444_5000, EXC_REFILL);
		acc(6'h0D, 32'h5555_6000, EXC_INV_LOAD);
		acc(6'h3D, 32'h6666_7000, EXC_INV_STORE);
		acc(6'h2E, 32'h7777_8000, EXC_MODIFIED);
		acc(6'h2F, 32'h8888_9000, EXC_NONE);
		wr(NUM_BADVA, SEL_0, 32'h0000_0000);
		rd(NUM_BADVA, SEL_0, last_va);
	endtask

	// Move the slot and boundary away from reset values first, or reset proves nothing
	task automatic reset_midrun();
		wr(NUM_WIRED, SEL_0, 32'h0000_0005);
		bw(1'b0, 1'b1, 6'h3F);
		rd(NUM_RAND, SEL_0, 32'h0000_003E);
		@(posedge mclk);
		rstn <= 1'b0;
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		rd(NUM_WIRED, SEL_0, 32'h0000_0000);
		rd(NUM_RAND, SEL_0, 32'h0000_003F);
		rd(NUM_PTR, SEL_MASK, 32'h0000_0000);
		bw(1'b0, 1'b1, 6'h3F);
	endtask

	initial begin
		repeat (4000) @(posedge mclk);
		miscompares++;
		summarize();
	end

	initial begin
		tests_run = 0;
		miscompares = 0;
		last_va = 32'h0000_0000;
		{cp0_wr, cp0_rd, indexed_entry_write, random_entry_write} = 4'h0;
		{translation_probe, probe_hit, acc_valid, acc_store} = 4'h0;
		{acc_user_sup, acc_perm_ok, acc_hit, acc_entry_valid, acc_entry_dirty} = 5'h00;
		{cp0_num, cp0_sel, probe_entry} = 14'h0000;
		cp0_wdata = 32'h0000_0000;
		acc_vaddr = 32'h0000_0000;
		rstn = 1'b0;
		repeat (20) @(posedge mclk);
		rstn <= 1'b1;
		reset_values();
		random_walk();
		probe_index();
		mask_sizing();
		fault_classes();
		pointer_capture();
		reset_midrun();
		summarize();
	end
endmodule
`default_nettype wire
